// ---- mag_pkg.sv ----
`default_nettype none
package mag_pkg;
  // Switch ports with their own maintenance alarms
  localparam int NUM_PORTS = 2;

  // Clock and derived timing
  localparam int CLK_HZ = 25_000_000;
  localparam int CLEAR_TIME_MS = 1000;
  localparam int CLEAR_CYCLES = CLK_HZ / 1000 * CLEAR_TIME_MS;
  localparam int SYNC_TIMEOUT_US = 1000;
  localparam int SYNC_TIMEOUT_CYCLES = CLK_HZ / 1_000_000 * SYNC_TIMEOUT_US;
  localparam int RATE_WINDOW_MS = 1000;
  localparam int RATE_WINDOW_CYCLES = CLK_HZ / 1000 * RATE_WINDOW_MS;

  // Counter widths
  localparam int CNT_W = 26;
  localparam int REJ_W = 4;
  localparam int PCNT_W = 6;
  localparam int INFO_W = 8;
  localparam int DET_W = 16;

  typedef logic [CNT_W-1:0] mag_cnt_t;

  // Frame rejection thresholds
  localparam logic [REJ_W-1:0] REJ_LEVEL1 = 4'h3;
  localparam logic [REJ_W-1:0] REJ_LEVEL2 = 4'hA;
  localparam logic [REJ_W-1:0] REJ_RESET = 4'h0;

  // Process interrupts accepted per rate window
  localparam logic [PCNT_W-1:0] PROC_MAX_PER_WIN = 6'h32;

  // Interrupt classes
  typedef enum logic [1:0] {
    CLS_DIAG = 2'h0,
    CLS_PROC = 2'h1,
    CLS_INSREM = 2'h2,
    CLS_MAINT = 2'h3
  } mag_class_t;

  // Start information bit positions
  localparam int INFO_INCOMING = 7;
  localparam int INFO_LEVEL2 = 6;
  localparam int INFO_SYNC = 5;
  localparam int INFO_PORT_LSB = 0;
endpackage
`default_nettype wire

// ---- mag_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mag_link_if;
  logic irq_valid;
  logic irq_ready;
  mag_pkg::mag_class_t irq_class;
  logic [mag_pkg::INFO_W-1:0] irq_info;
  logic det_req;
  logic det_valid;
  logic [mag_pkg::DET_W-1:0] det_data;

  modport device (
    output irq_valid,
    output irq_class,
    output irq_info,
    output det_valid,
    output det_data,
    input irq_ready,
    input det_req
  );

  modport controller (
    input irq_valid,
    input irq_class,
    input irq_info,
    input det_valid,
    input det_data,
    output irq_ready,
    output det_req
  );
endinterface
`default_nettype wire

// ---- mag_device.sv ----
// Contract
// - Three rejected frames raise maintenance-required alarm
// - Ten rejected frames raise maintenance-demanded alarm
// - Rejection alarms self-clear one second after raise
// - Sync frame timeout raises sync-loss alarm
// - Excess sync jitter raises sync-loss alarm
// - Slave resynchronization reports jitter out of limits
// - Rejection alarms per port, required versus demanded
// - Four interrupt classes toward the controller
// - Diagnostic interrupt per event when enabled
// - Controller runs diagnostic handler with start info
// - Controller runs process handler with start info
// - Controller runs insert/remove handler with start info
// - Controller may read interrupt detail in handler
// - Process interrupts beyond fifty per second dropped
// - Maintenance interrupts flag network parts to check
`timescale 1ns/1ps
`default_nettype none
module mag_device #(
  parameter int CLEAR_CYCLES = mag_pkg::CLEAR_CYCLES,
  parameter int SYNC_TIMEOUT_CYCLES = mag_pkg::SYNC_TIMEOUT_CYCLES,
  parameter int RATE_WINDOW_CYCLES = mag_pkg::RATE_WINDOW_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Link to the controller
  mag_link_if.device link,
  // Switch frame rejections, one pulse per discarded frame
  input wire logic [mag_pkg::NUM_PORTS-1:0] rej_pulse,
  // Clock synchronization monitor
  input wire logic sync_monitor_en,
  input wire logic sync_frame,
  input wire logic [7:0] sync_jitter,
  input wire logic [7:0] jitter_limit,
  input wire logic resync,
  // Diagnostic events
  input wire logic diag_irq_en,
  input wire logic diag_event,
  input wire logic diag_incoming,
  input wire logic [7:0] diag_code,
  // Process events
  input wire logic proc_event,
  input wire logic [7:0] proc_code,
  // Module insert/remove events
  input wire logic insrem_event,
  input wire logic insrem_inserted,
  input wire logic [7:0] insrem_slot,
  // Status
  output logic [mag_pkg::NUM_PORTS-1:0] maint_required,
  output logic [mag_pkg::NUM_PORTS-1:0] maint_demanded,
  output logic sync_lost,
  output logic proc_irq_lost
);
  localparam int NP = mag_pkg::NUM_PORTS;
  localparam int IW = mag_pkg::INFO_W;

  typedef struct packed {
    logic [NP-1:0][mag_pkg::REJ_W-1:0] rej_cnt;
    logic [NP-1:0] alarm_req;
    logic [NP-1:0] alarm_dem;
    logic [NP-1:0][mag_pkg::CNT_W-1:0] clr_cnt;
    logic sync_loss;
    logic [mag_pkg::CNT_W-1:0] sync_cnt;
    logic [3:0] pend;
    logic [3:0][IW-1:0] pinfo;
    logic [3:0][7:0] pdet;
    logic [mag_pkg::CNT_W-1:0] win_cnt;
    logic [mag_pkg::PCNT_W-1:0] proc_cnt;
    logic proc_lost;
    logic irq_valid;
    logic [1:0] irq_class;
    logic [IW-1:0] irq_info;
    logic [7:0] irq_det;
    logic [IW-1:0] taken_info;
    logic [7:0] taken_det;
    logic det_valid;
    logic [mag_pkg::DET_W-1:0] det_data;
  } mag_dev_state_t;

  mag_dev_state_t st;
  mag_dev_state_t next_st;

  logic [mag_pkg::REJ_W-1:0] new_cnt;
  logic jit_evt;
  logic sync_timeout;
  logic [IW-1:0] minfo;

  always_comb begin
    next_st = st;
    new_cnt = '0;
    minfo = '0;
    next_st.proc_lost = 1'b0;
    next_st.det_valid = 1'b0;

    // Interrupt delivery; runs first so new events win over the clear
    if (st.irq_valid && link.irq_ready) begin
      next_st.irq_valid = 1'b0;
      // Detail reads answer for the interrupt taken, not a newer one
      next_st.taken_info = st.irq_info;
      next_st.taken_det = st.irq_det;
    end else if (!st.irq_valid) begin
      for (int c = 3; c >= 0; c--) begin
        if (st.pend[c]) begin
          next_st.irq_valid = 1'b1;
          next_st.irq_class = 2'(c);
          next_st.irq_info = st.pinfo[c];
          next_st.irq_det = st.pdet[c];
        end
      end
      for (int c = 3; c >= 0; c--) begin
        if (st.pend[c] && (next_st.irq_class == 2'(c))) begin
          next_st.pend[c] = 1'b0;
        end
      end
    end

    if (link.det_req) begin
      next_st.det_valid = 1'b1;
      next_st.det_data = {st.taken_info, st.taken_det};
    end

    // Frame rejection alarms per port
    for (int p = 0; p < NP; p++) begin
      minfo = '0;
      minfo[mag_pkg::INFO_PORT_LSB +: 4] = 4'(p);
      if (st.alarm_req[p] || st.alarm_dem[p]) begin
        if (st.clr_cnt[p] == mag_pkg::mag_cnt_t'(CLEAR_CYCLES - 1)) begin
          next_st.alarm_req[p] = 1'b0;
          next_st.alarm_dem[p] = 1'b0;
          next_st.clr_cnt[p] = '0;
          next_st.rej_cnt[p] = mag_pkg::REJ_RESET;
          next_st.pend[mag_pkg::CLS_MAINT] = 1'b1;
          next_st.pinfo[mag_pkg::CLS_MAINT] = minfo;
          next_st.pdet[mag_pkg::CLS_MAINT] = 8'(st.rej_cnt[p]);
        end else begin
          next_st.clr_cnt[p] = st.clr_cnt[p] + mag_pkg::mag_cnt_t'(1);
        end
      end
      if (rej_pulse[p] && (next_st.rej_cnt[p] != mag_pkg::REJ_LEVEL2)) begin
        new_cnt = next_st.rej_cnt[p] + 4'h1;
        next_st.rej_cnt[p] = new_cnt;
        minfo[mag_pkg::INFO_INCOMING] = 1'b1;
        if ((new_cnt == mag_pkg::REJ_LEVEL1) && !next_st.alarm_req[p]) begin
          next_st.alarm_req[p] = 1'b1;
          next_st.clr_cnt[p] = '0;
          next_st.pend[mag_pkg::CLS_MAINT] = 1'b1;
          next_st.pinfo[mag_pkg::CLS_MAINT] = minfo;
          next_st.pdet[mag_pkg::CLS_MAINT] = 8'(new_cnt);
        end
        if (new_cnt == mag_pkg::REJ_LEVEL2) begin
          next_st.alarm_dem[p] = 1'b1;
          next_st.clr_cnt[p] = '0;
          minfo[mag_pkg::INFO_LEVEL2] = 1'b1;
          next_st.pend[mag_pkg::CLS_MAINT] = 1'b1;
          next_st.pinfo[mag_pkg::CLS_MAINT] = minfo;
          next_st.pdet[mag_pkg::CLS_MAINT] = 8'(new_cnt);
        end
      end
    end

    jit_evt = (sync_frame && (sync_jitter > jitter_limit)) || resync;
    sync_timeout = sync_monitor_en && !sync_frame &&
                   (st.sync_cnt == mag_pkg::mag_cnt_t'(SYNC_TIMEOUT_CYCLES - 1));
    if (!sync_monitor_en || sync_frame || sync_timeout) begin
      next_st.sync_cnt = '0;
    end else begin
      next_st.sync_cnt = st.sync_cnt + mag_pkg::mag_cnt_t'(1);
    end
    minfo = '0;
    minfo[mag_pkg::INFO_SYNC] = 1'b1;
    if ((sync_timeout || jit_evt) && !st.sync_loss) begin
      next_st.sync_loss = 1'b1;
      minfo[mag_pkg::INFO_INCOMING] = 1'b1;
      next_st.pend[mag_pkg::CLS_MAINT] = 1'b1;
      next_st.pinfo[mag_pkg::CLS_MAINT] = minfo;
      next_st.pdet[mag_pkg::CLS_MAINT] = {7'h00, jit_evt};
    end else if (sync_frame && !jit_evt && st.sync_loss) begin
      next_st.sync_loss = 1'b0;
      next_st.pend[mag_pkg::CLS_MAINT] = 1'b1;
      next_st.pinfo[mag_pkg::CLS_MAINT] = minfo;
      next_st.pdet[mag_pkg::CLS_MAINT] = 8'h00;
    end

    if (diag_event && diag_irq_en) begin
      next_st.pend[mag_pkg::CLS_DIAG] = 1'b1;
      next_st.pinfo[mag_pkg::CLS_DIAG] = {diag_incoming, 7'h00};
      next_st.pdet[mag_pkg::CLS_DIAG] = diag_code;
    end

    if (insrem_event) begin
      next_st.pend[mag_pkg::CLS_INSREM] = 1'b1;
      next_st.pinfo[mag_pkg::CLS_INSREM] = {insrem_inserted, 7'h00};
      next_st.pdet[mag_pkg::CLS_INSREM] = insrem_slot;
    end

    if (st.win_cnt == mag_pkg::mag_cnt_t'(RATE_WINDOW_CYCLES - 1)) begin
      next_st.win_cnt = '0;
      next_st.proc_cnt = '0;
    end else begin
      next_st.win_cnt = st.win_cnt + mag_pkg::mag_cnt_t'(1);
    end
    if (proc_event) begin
      if ((next_st.proc_cnt == mag_pkg::PROC_MAX_PER_WIN) || next_st.pend[mag_pkg::CLS_PROC]) begin
        next_st.proc_lost = 1'b1;
      end else begin
        next_st.proc_cnt = next_st.proc_cnt + 6'h01;
        next_st.pend[mag_pkg::CLS_PROC] = 1'b1;
        next_st.pinfo[mag_pkg::CLS_PROC] = 8'h00;
        next_st.pdet[mag_pkg::CLS_PROC] = proc_code;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign maint_required = st.alarm_req;
  assign maint_demanded = st.alarm_dem;
  assign sync_lost = st.sync_loss;
  assign proc_irq_lost = st.proc_lost;
  assign link.irq_valid = st.irq_valid;
  assign link.irq_class = mag_pkg::mag_class_t'(st.irq_class);
  assign link.irq_info = st.irq_info;
  assign link.det_valid = st.det_valid;
  assign link.det_data = st.det_data;
endmodule
`default_nettype wire

// ---- mag_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
module mag_controller (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Link to the device
  mag_link_if.controller link,
  // User program side
  input wire logic handler_done,
  input wire logic fetch_req,
  output logic user_prog_suspended,
  output logic diag_irq_handler_start,
  output logic process_irq_handler_start,
  output logic insert_remove_handler_start,
  output logic maint_irq_handler_start,
  output logic [mag_pkg::INFO_W-1:0] start_info,
  output logic [mag_pkg::DET_W-1:0] detail_data,
  output logic detail_valid
);
  typedef enum logic [2:0] {
    C_IDLE = 3'h1,
    C_HANDLE = 3'h2,
    C_FETCH = 3'h4
  } mag_ctl_state_t;

  typedef struct packed {
    mag_ctl_state_t state;
    logic [3:0] start;
    logic [mag_pkg::INFO_W-1:0] info;
    logic det_req;
    logic [mag_pkg::DET_W-1:0] detail;
    logic detail_valid;
  } mag_ctl_t;

  mag_ctl_t st;
  mag_ctl_t next_st;

  always_comb begin
    next_st = st;
    next_st.start = 4'h0;
    next_st.det_req = 1'b0;
    next_st.detail_valid = 1'b0;
    case (st.state)
      C_IDLE: begin
        if (link.irq_valid) begin
          next_st.start[link.irq_class] = 1'b1;
          next_st.info = link.irq_info;
          next_st.state = C_HANDLE;
        end
      end
      C_HANDLE: begin
        if (fetch_req) begin
          next_st.det_req = 1'b1;
          next_st.state = C_FETCH;
        end else if (handler_done) begin
          next_st.state = C_IDLE;
        end
      end
      C_FETCH: begin
        if (link.det_valid) begin
          next_st.detail = link.det_data;
          next_st.detail_valid = 1'b1;
          next_st.state = C_HANDLE;
        end
      end
      default: begin
        next_st.state = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st <= '0;
      st.state <= C_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign link.irq_ready = (st.state == C_IDLE);
  assign link.det_req = st.det_req;
  assign user_prog_suspended = (st.state != C_IDLE);
  assign diag_irq_handler_start = st.start[mag_pkg::CLS_DIAG];
  assign process_irq_handler_start = st.start[mag_pkg::CLS_PROC];
  assign insert_remove_handler_start = st.start[mag_pkg::CLS_INSREM];
  assign maint_irq_handler_start = st.start[mag_pkg::CLS_MAINT];
  assign start_info = st.info;
  assign detail_data = st.detail;
  assign detail_valid = st.detail_valid;
endmodule
`default_nettype wire

// ---- mag_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module mag_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Link signals
  input wire logic irq_valid,
  input wire logic irq_ready,
  input wire mag_pkg::mag_class_t irq_class,
  input wire logic [mag_pkg::INFO_W-1:0] irq_info,
  input wire logic det_req,
  input wire logic det_valid,
  input wire logic [mag_pkg::DET_W-1:0] det_data
);
  logic [7:0] last_info;

  // Start information of the interrupt last taken
  always_ff @(posedge core_clk) begin
    if (irq_valid && irq_ready) begin
      last_info <= irq_info;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  AST_HOLD: assert property (irq_valid && !irq_ready |=> irq_valid && $stable(irq_class) && $stable(irq_info))
    else $error("Pending interrupt changed before it was taken");
  AST_DROP: assert property (irq_valid && irq_ready |=> !irq_valid)
    else $error("Interrupt still offered after acceptance");
  AST_BUSY: assert property (irq_valid && irq_ready |=> !irq_ready)
    else $error("Controller ready while running a handler");
  AST_DET_ANSWER: assert property (det_req |=> det_valid)
    else $error("Detail request not answered in one cycle");
  AST_DET_CAUSE: assert property (det_valid |-> $past(det_req))
    else $error("Detail answer without request");
  AST_DET_PULSE: assert property (det_valid |=> !det_valid)
    else $error("Detail answer longer than one cycle");
  AST_DET_INFO: assert property (det_valid |-> det_data[15:8] == last_info)
    else $error("Detail data does not carry last start information");
  AST_DET_HOLD: assert property (!det_valid |-> $stable(det_data))
    else $error("Detail data changed without answer");
  AST_PORT: assert property (irq_valid && irq_class == mag_pkg::CLS_MAINT && !irq_info[mag_pkg::INFO_SYNC]
    |-> irq_info[3:0] < mag_pkg::NUM_PORTS)
    else $error("Maintenance interrupt names a missing port");

  COV_MAINT: cover property (irq_valid && irq_ready && irq_class == mag_pkg::CLS_MAINT);
  COV_DIAG: cover property (irq_valid && irq_ready && irq_class == mag_pkg::CLS_DIAG);
  COV_DET: cover property (det_req ##1 det_valid);
endmodule
`default_nettype wire

// ---- maintenance_alarm_generator_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module maintenance_alarm_generator_test;
  logic core_clk, rstn, sync_monitor_en, sync_frame, resync, diag_irq_en, diag_event, diag_incoming;
  logic proc_event, insrem_event, insrem_inserted, handler_done, fetch_req;
  logic [1:0] rej_pulse, maint_required, maint_demanded;
  logic [7:0] sync_jitter, jitter_limit, diag_code, proc_code, insrem_slot, start_info;
  logic sync_lost, proc_irq_lost, user_prog_suspended, detail_valid;
  logic diag_irq_handler_start, process_irq_handler_start, insert_remove_handler_start, maint_irq_handler_start;
  logic [15:0] detail_data;
  int errors, n_checks, lost;
  wire logic [3:0] starts = {diag_irq_handler_start, process_irq_handler_start,
    insert_remove_handler_start, maint_irq_handler_start};

  mag_link_if u_mag_link_if ();
  mag_device #(.CLEAR_CYCLES(50), .SYNC_TIMEOUT_CYCLES(20), .RATE_WINDOW_CYCLES(1000)) u_mag_device (
    .core_clk, .rstn, .link(u_mag_link_if), .rej_pulse, .sync_monitor_en, .sync_frame, .sync_jitter,
    .jitter_limit, .resync, .diag_irq_en, .diag_event, .diag_incoming, .diag_code, .proc_event, .proc_code,
    .insrem_event, .insrem_inserted, .insrem_slot, .maint_required, .maint_demanded, .sync_lost, .proc_irq_lost);
  mag_controller u_mag_controller (
    .core_clk, .rstn, .link(u_mag_link_if), .handler_done, .fetch_req, .user_prog_suspended,
    .diag_irq_handler_start, .process_irq_handler_start, .insert_remove_handler_start,
    .maint_irq_handler_start, .start_info, .detail_data, .detail_valid);
  mag_monitor u_mag_monitor (
    .core_clk, .rstn, .irq_valid(u_mag_link_if.irq_valid), .irq_ready(u_mag_link_if.irq_ready),
    .irq_class(u_mag_link_if.irq_class), .irq_info(u_mag_link_if.irq_info), .det_req(u_mag_link_if.det_req),
    .det_valid(u_mag_link_if.det_valid), .det_data(u_mag_link_if.det_data));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Waits for a handler start, judges it, optionally reads detail, then ends the handler
  task automatic serve(input logic [3:0] cls, input logic [7:0] info, input logic [7:0] mask, input bit fetch);
    int i;
    i = 0;
    #1;
    while (starts === 4'h0 && i < 100) begin
      tick(1);
      i++;
    end
    check(starts, cls);
    check(start_info & mask, info);
    check(user_prog_suspended, 1'b1);
    if (fetch) begin
      @(posedge core_clk);
      fetch_req <= 1'b1;
      @(posedge core_clk);
      fetch_req <= 1'b0;
      tick(2);
      check({detail_valid, detail_data[15:8] & mask}, {1'b1, info});
    end
    @(posedge core_clk);
    handler_done <= 1'b1;
    @(posedge core_clk);
    handler_done <= 1'b0;
  endtask

  task automatic rej();
    @(posedge core_clk);
    rej_pulse <= 2'h2;
    @(posedge core_clk);
    rej_pulse <= 2'h0;
  endtask

  task automatic t_rej();
    rej();
    rej();
    tick(3);
    check(maint_required, 2'h0);
    rej();
    serve(4'h1, 8'h81, 8'hCF, 0);
    check({maint_required, maint_demanded}, 4'h8);
    repeat (6) rej();
    tick(3);
    check(maint_demanded, 2'h0);
    rej();
    serve(4'h1, 8'hC1, 8'hCF, 1);
    check(detail_data[7:0], 8'h0A);
    check(maint_demanded, 2'h2);
    tick(20);
    check({maint_required, maint_demanded}, 4'hA);
    serve(4'h1, 8'h01, 8'h8F, 0);
    check({maint_required, maint_demanded}, 4'h0);
    rej();
    rej();
    tick(3);
    check(maint_required, 2'h0);
    repeat (3) begin
      @(posedge core_clk);
      rej_pulse <= 2'h1;
      @(posedge core_clk);
      rej_pulse <= 2'h0;
    end
    serve(4'h1, 8'h80, 8'hCF, 0);
    check({maint_required, maint_demanded}, 4'h4);
    serve(4'h1, 8'h00, 8'h8F, 0);
    check(maint_required, 2'h0);
  endtask

  task automatic sync_ev(input logic f, input logic [7:0] j, input logic r, input logic exp);
    @(posedge core_clk);
    sync_frame <= f;
    sync_jitter <= j;
    resync <= r;
    @(posedge core_clk);
    sync_frame <= 1'b0;
    resync <= 1'b0;
    serve(4'h1, {exp, 7'h20}, 8'hA0, 0);
    check(sync_lost, exp);
  endtask

  task automatic t_sync();
    @(posedge core_clk);
    sync_monitor_en <= 1'b1;
    serve(4'h1, 8'hA0, 8'hA0, 0);
    check(sync_lost, 1'b1);
    @(posedge core_clk);
    sync_monitor_en <= 1'b0;
    sync_ev(1, 8'h10, 0, 0);
    sync_ev(1, 8'h11, 0, 1);
    sync_ev(1, 8'h00, 0, 0);
    sync_ev(0, 8'h00, 1, 1);
    sync_ev(1, 8'h00, 0, 0);
  endtask

  task automatic diag(input logic en, input logic inc);
    @(posedge core_clk);
    diag_irq_en <= en;
    diag_incoming <= inc;
    diag_event <= 1'b1;
    @(posedge core_clk);
    diag_event <= 1'b0;
  endtask

  task automatic t_diag();
    diag(0, 1);
    tick(6);
    check({u_mag_link_if.irq_valid, user_prog_suspended}, 2'h0);
    diag(1, 1);
    serve(4'h8, 8'h80, 8'h80, 1);
    check(detail_data[7:0], 8'h5A);
    diag(1, 0);
    serve(4'h8, 8'h00, 8'h80, 0);
  endtask

  // Three process event cycles: the third finds the second still pending
  task automatic t_proc();
    @(posedge core_clk);
    proc_event <= 1'b1;
    tick(2);
    @(posedge core_clk);
    proc_event <= 1'b0;
    serve(4'h4, 8'h00, 8'h00, 1);
    check(detail_data[7:0], 8'h33);
    serve(4'h4, 8'h00, 8'h00, 0);
    check(lost[15:0], 16'h0001);
    @(posedge core_clk);
    insrem_event <= 1'b1;
    @(posedge core_clk);
    insrem_event <= 1'b0;
    serve(4'h2, 8'h80, 8'h80, 1);
    check(detail_data[7:0], 8'h03);
  endtask

  // Fifty-one process events in one rate window: only the last is dropped
  task automatic t_rate();
    int base;
    do begin
      tick(1);
    end while (u_mag_device.st.win_cnt != '0);
    base = lost;
    repeat (50) begin
      @(posedge core_clk);
      proc_event <= 1'b1;
      @(posedge core_clk);
      proc_event <= 1'b0;
      serve(4'h4, 8'h00, 8'h00, 0);
    end
    @(posedge core_clk);
    proc_event <= 1'b1;
    @(posedge core_clk);
    proc_event <= 1'b0;
    tick(4);
    check(16'(lost - base), 16'h0001);
    check(starts, 4'h0);
  endtask

  always @(posedge core_clk) begin
    if (proc_irq_lost === 1'b1) begin
      lost++;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    {rstn, sync_monitor_en, sync_frame, resync, diag_irq_en, diag_event, diag_incoming} = '0;
    {proc_event, insrem_event, handler_done, fetch_req, rej_pulse, sync_jitter} = '0;
    {diag_code, proc_code, insrem_slot} = 24'h5A3303;
    insrem_inserted = 1'b1;
    jitter_limit = 8'h10;
    errors = 0;
    n_checks = 0;
    lost = 0;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    tick(1);
    t_rej();
    t_sync();
    t_diag();
    t_proc();
    t_rate();
    finish_test();
  end

  initial begin
    #2000000;
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
